// *** shared/regpwm_pkg.sv ***
package regpwm_pkg;

	// register byte addresses on the apb bus
	localparam logic [11:0] CFG_ADDR  = 12'h000;
	localparam logic [11:0] STAT_ADDR = 12'h004;

	// power_config_reg fields
	localparam int          CFG_W          = 6;
	localparam int          CFG_BOOST_EN   = 0;
	localparam int          CFG_LINREG_EN  = 1;
	localparam int          CFG_SPREAD_EN  = 2;
	localparam int          CFG_SPREAD_TRI = 3;
	localparam int          CFG_B2_EN      = 4;
	localparam int          CFG_B3_EN      = 5;
	localparam logic [5:0]  CFG_RST        = 6'h30;

	// power_status_reg fields; bits 4:0 are sticky, write one to clear
	localparam int          FLAG_W         = 5;
	localparam int          ST_BOOST_FAIL  = 0;
	localparam int          ST_BOOST_OT    = 1;
	localparam int          ST_LINREG_OT   = 2;
	localparam int          ST_LINREG_FAIL = 3;
	localparam int          ST_OV_TRIP     = 4;
	localparam int          ST_CODE_LSB    = 8;
	localparam int          ST_MAIN_ACT    = 12;
	localparam int          ST_PERI_ACT    = 13;
	localparam int          ST_BLANK_LSB   = 16;
	localparam int          ST_MAIN_PIN    = 20;
	localparam int          ST_PERI_PIN    = 21;

	// oscillator and switching timing
	localparam int          CLK_PERIOD_NS  = 10;
	localparam logic [6:0]  OSC_NOM_CYC    = 7'h3c;
	localparam logic [3:0]  FREQ_CODE_MAX  = 4'hf;
	localparam logic [3:0]  PRE_TICKS      = 4'ha;
	localparam logic [1:0]  BOOT_PERIOD    = 2'h3;
	localparam int          DEAD_PRE_NS    = 25;
	localparam int          DEAD_POST_NS   = 20;
	localparam logic [2:0]  DEAD_PRE_CYC   =
		3'((DEAD_PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0]  DEAD_POST_CYC  =
		3'((DEAD_POST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// current-limit protection
	localparam logic [2:0]  LIM_HITS       = 3'h5;
	localparam logic [4:0]  BLANK_CYCLES   = 5'h10;
	localparam logic [2:0]  LS_BLANK_CYC   = 3'h3;

	// reset stretch
	localparam int          MAIN_RESET_OUT_HOLD_US   = 1000;

endpackage : regpwm_pkg

// *** logic/post_conv.sv ***
`timescale 1ns/1ps
`default_nettype none

module post_conv #(
	parameter bit SYNC = 1'b1
) (
	input  wire logic core_clk,  // core clock
	input  wire logic rst_n,     // async reset, active low
	input  wire logic ce,        // clock enable
	input  wire logic enable,    // converter enabled
	input  wire logic cycStart,  // switching cycle start pulse
	input  wire logic pwmOff,    // modulator ends on-time
	input  wire logic dutyCap,   // forced end of on-time
	input  wire logic skip,      // skip this cycle
	input  wire logic hsLimit,   // main switch current limit
	input  wire logic lsLimit,   // low-side current limit
	output wire logic hsGate,    // main switch gate
	output wire logic lsGate,    // low-side gate
	output wire logic blanking   // forced-off window running
);

	typedef enum logic [3:0] {
		S_OFF  = 4'b0001,
		S_HS   = 4'b0010,
		S_DEAD = 4'b0100,
		S_LS   = 4'b1000
	} conv_st_t;

	conv_st_t   st_r,    st_nxt;
	logic [2:0] dly_r,   dly_nxt;
	logic [2:0] hits_r,  hits_nxt;
	logic [4:0] blank_r, blank_nxt;
	logic [2:0] lsBl_r,  lsBl_nxt;
	logic       early_r, early_nxt;

	// gates are state bits, so they leave straight from flops
	assign hsGate   = st_r[1];
	assign lsGate   = st_r[3];
	assign blanking = blank_r != 5'h00;

	// cycle sequencing and limit counting
	always_comb
	begin
		st_nxt    = st_r;
		dly_nxt   = dly_r;
		hits_nxt  = hits_r;
		blank_nxt = blank_r;
		lsBl_nxt  = lsBl_r;
		early_nxt = 1'b0;
		if (!enable)
		begin
			st_nxt    = S_OFF;
			hits_nxt  = 3'h0;
			blank_nxt = 5'h00;
		end
		else if (cycStart)
		begin
			hits_nxt = hsLimit ? hits_r + 3'h1 : 3'h0;
			if (blank_r != 5'h00)
			begin
				blank_nxt = blank_r - 5'h01;
				st_nxt    = S_OFF;
			end
			else if (hsLimit && hits_r == regpwm_pkg::LIM_HITS - 3'h1)
			begin
				blank_nxt = regpwm_pkg::BLANK_CYCLES;
				hits_nxt  = 3'h0;
				st_nxt    = S_OFF;
			end
			else if (skip)
				st_nxt = S_OFF;
			else
				st_nxt = S_HS;
		end
		else
		begin
			case (st_r)
				S_HS:
					if (hsLimit || pwmOff || dutyCap)
					begin
						st_nxt  = SYNC ? S_DEAD : S_OFF;
						dly_nxt = regpwm_pkg::DEAD_POST_CYC - 3'h1;
					end
				S_DEAD:
					if (dly_r == 3'h0)
					begin
						st_nxt   = S_LS;
						lsBl_nxt = regpwm_pkg::LS_BLANK_CYC;
					end
					else
						dly_nxt = dly_r - 3'h1;
				S_LS:
					// comparator ignored while blanked
					if (lsBl_r != 3'h0)
					begin
						lsBl_nxt  = lsBl_r - 3'h1;
						early_nxt = lsBl_r == 3'h1;
					end
					else if (lsLimit)
					begin
						st_nxt = S_OFF;
						if (early_r)
							blank_nxt = regpwm_pkg::BLANK_CYCLES;
					end
				S_OFF:
					st_nxt = S_OFF;
				default:
					st_nxt = S_OFF;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r    <= S_OFF;
			dly_r   <= 3'h0;
			hits_r  <= 3'h0;
			blank_r <= 5'h00;
			lsBl_r  <= 3'h0;
			early_r <= 1'b0;
		end
		else if (ce)
		begin
			st_r    <= st_nxt;
			dly_r   <= dly_nxt;
			hits_r  <= hits_nxt;
			blank_r <= blank_nxt;
			lsBl_r  <= lsBl_nxt;
			early_r <= early_nxt;
		end
	end

endmodule : post_conv

`default_nettype wire

// *** logic/spread_gen.sv ***
`timescale 1ns/1ps
`default_nettype none

module spread_gen (
	input  wire logic       core_clk, // core clock
	input  wire logic       rst_n,    // async reset, active low
	input  wire logic       ce,       // clock enable
	input  wire logic       enable,   // spreading on
	input  wire logic       triMode,  // 1 triangle, 0 pseudo-random
	input  wire logic       step,     // once per pre-regulator cycle
	output wire logic [3:0] code      // oscillator frequency code
);

	logic [3:0] code_r, code_nxt;
	logic [3:0] lfsr_r, lfsr_nxt;
	logic       up_r,   up_nxt;
	logic       goUp;

	assign code = code_r;

	// single-step walk while enabled; disabling sends the code straight back to 0
	always_comb
	begin
		code_nxt = code_r;
		lfsr_nxt = lfsr_r;
		up_nxt   = up_r;
		goUp     = up_r;
		if (!enable)
		begin
			code_nxt = 4'h0;
			up_nxt   = 1'b1;
		end
		else if (step)
		begin
			lfsr_nxt = {lfsr_r[2:0], lfsr_r[3] ^ lfsr_r[2]};
			goUp     = triMode ? up_r : lfsr_r[0];
			if (code_r == regpwm_pkg::FREQ_CODE_MAX)
				goUp = 1'b0;
			if (code_r == 4'h0)
				goUp = 1'b1;
			code_nxt = goUp ? code_r + 4'h1 : code_r - 4'h1;
			up_nxt   = goUp;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			code_r <= 4'h0;
			lfsr_r <= 4'h1; // lfsr must never hold all zeros
			up_r   <= 1'b1;
		end
		else if (ce)
		begin
			code_r <= code_nxt;
			lfsr_r <= lfsr_nxt;
			up_r   <= up_nxt;
		end
	end

endmodule : spread_gen

`default_nettype wire

// *** logic/regulator_pwm_protection_ctl.sv ***
`timescale 1ns/1ps
`default_nettype none

module regulator_pwm_protection_ctl #(
	parameter int MAIN_RESET_OUT_HOLD_US = regpwm_pkg::MAIN_RESET_OUT_HOLD_US
) (
	input  wire logic        core_clk,          // core clock, 100 MHz
	input  wire logic        rst_n,             // async reset, active low
	input  wire logic        ce,                // clock enable
	input  wire logic        psel,              // apb select
	input  wire logic        penable,           // apb enable
	input  wire logic        pwrite,            // apb write
	input  wire logic [11:0] paddr,             // apb byte address
	input  wire logic [31:0] pwdata,            // apb write data
	output var  logic [31:0] prdata,            // apb read data
	output var  logic        pready,            // apb ready
	output var  logic        pslverr,           // apb error
	input  wire logic        preregPeakTrip,    // peak-current comparator
	output wire logic        preregHsGate,      // pre-regulator high gate
	output wire logic        preregLsGate,      // pre-regulator low gate
	input  wire logic        b2PwmOff,          // second rail on-time end
	input  wire logic        b2HsLimit,         // second rail high limit
	input  wire logic        b2LsLimit,         // second rail low limit
	output wire logic        b2HsGate,          // second rail high gate
	output wire logic        b2LsGate,          // second rail low gate
	input  wire logic        b3PwmOff,          // third rail on-time end
	input  wire logic        b3HsLimit,         // third rail high limit
	input  wire logic        b3LsLimit,         // third rail low limit
	output wire logic        b3HsGate,          // third rail high gate
	output wire logic        b3LsGate,          // third rail low gate
	input  wire logic        boostPwmOff,       // boost on-time end
	input  wire logic        boostLimit,        // boost switch limit
	input  wire logic        boostLowLoad,      // boost pulse skip request
	output wire logic        boostSwitch,       // boost low-side switch
	input  wire logic        boostWinFault,     // boost out of window
	input  wire logic        boostOtIn,         // boost overtemperature
	input  wire logic        linregWinFault,    // linreg out of window
	input  wire logic        linregOtIn,        // linreg overtemperature
	input  wire logic        linregOvIn,        // linreg overvoltage
	input  wire logic        voltageCheckState, // device in voltage check
	input  wire logic        rampState,         // device in ramp
	input  wire logic        activeState,       // device active
	input  wire logic        fetRequest,        // sequencer wants fet on
	output var  logic        externalProtectionFet, // protection fet on
	output var  logic        errorRequest,      // request error state
	output var  logic        linregOn,          // linreg running
	output var  logic        auxSupplyAllow,    // gate_driver_supply may use aux_supply_pin
	output wire logic [3:0]  freqCode,          // oscillator frequency code
	input  wire logic        resetTrigger,      // any reset condition
	input  wire logic        watchdogTriggerPin, // watchdog trigger input
	input  wire logic        mainResetIn,       // main_reset_out pin level
	output var  logic        mainResetOut,      // main_reset_out drive value
	output var  logic        mainResetOeN,      // main reset drive, low drives
	input  wire logic        periResetIn,       // peripheral_reset_out level
	output var  logic        periResetOut,      // peripheral reset value
	output var  logic        periResetOeN       // peripheral drive, low drives
);

	localparam int HOLD_CYC =
		MAIN_RESET_OUT_HOLD_US * 1000 / regpwm_pkg::CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		P_OFF  = 4'b0001,
		P_HS   = 4'b0010,
		P_DEAD = 4'b0100,
		P_LS   = 4'b1000
	} pre_st_t;

	function automatic logic [6:0] halfOf(input logic [6:0] p);
		halfOf = {1'b0, p[6:1]};
	endfunction : halfOf

	// oscillator state
	logic [6:0] oscPer;
	logic [6:0] phase_r, phase_nxt;
	logic [3:0] tickIdx_r, tickIdx_nxt;
	logic       oscWrap;
	logic       preStart;
	logic       pairStart;
	logic       b2Start;
	logic       pastHalf;

	// pre-regulator state
	pre_st_t    preSt_r, preSt_nxt;
	logic [2:0] preDly_r, preDly_nxt;
	logic [1:0] bootCnt_r, bootCnt_nxt;
	logic       bootCap;

	// register and protection state
	logic [regpwm_pkg::CFG_W-1:0]  cfg_r, cfg_nxt;
	logic [regpwm_pkg::FLAG_W-1:0] flags_r, flags_nxt;
	logic [31:0] rdata_nxt;
	logic        ready_nxt;
	logic        err_nxt;
	logic        ovTrip_r, ovTrip_nxt;
	logic        fet_nxt;
	logic        apbSetup;
	logic        apbAccess;
	logic        wrCfg;
	logic        wrStat;
	logic [31:0] statusWord;

	// reset stretch state
	logic [23:0] hold_r, hold_nxt;
	logic        mainAct_r, mainAct_nxt;
	logic        periAct_r, periAct_nxt;
	logic        wdPrev_r;
	logic        wdRise;

	logic [2:0]  blankVec;

	// one oscillator paces every rail; spreading lengthens its period
	assign oscPer    = regpwm_pkg::OSC_NOM_CYC + {3'h0, freqCode};
	assign oscWrap   = phase_r == oscPer - 7'h01;
	assign preStart  = oscWrap && tickIdx_r == regpwm_pkg::PRE_TICKS - 4'h1;
	assign pairStart = oscWrap && tickIdx_r[0];
	// 216 degrees is one tick plus a fifth of the next
	assign b2Start   = tickIdx_r[0] && phase_r == oscPer / 7'h05;
	assign pastHalf  = phase_r >= halfOf(oscPer);
	assign bootCap   = bootCnt_r == regpwm_pkg::BOOT_PERIOD &&
		tickIdx_r == regpwm_pkg::PRE_TICKS - 4'h1 && pastHalf;

	always_comb
	begin
		phase_nxt   = oscWrap ? 7'h00 : phase_r + 7'h01;
		tickIdx_nxt = tickIdx_r;
		if (oscWrap)
			tickIdx_nxt = (tickIdx_r == regpwm_pkg::PRE_TICKS - 4'h1) ?
				4'h0 : tickIdx_r + 4'h1;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_r   <= 7'h00;
			tickIdx_r <= 4'h0;
		end
		else if (ce)
		begin
			phase_r   <= phase_nxt;
			tickIdx_r <= tickIdx_nxt;
		end
	end

	// pre-regulator gate sequence
	assign preregHsGate = preSt_r[1];
	assign preregLsGate = preSt_r[3];

	always_comb
	begin
		preSt_nxt   = preSt_r;
		preDly_nxt  = preDly_r;
		bootCnt_nxt = bootCnt_r;
		if (preStart)
		begin
			preSt_nxt   = P_HS;
			bootCnt_nxt = bootCnt_r + 2'h1;
		end
		else
		begin
			case (preSt_r)
				P_HS:
					// no trip in dropout: gate stays on until bootCap cuts it in every fourth cycle
					if (preregPeakTrip || bootCap)
					begin
						preSt_nxt  = P_DEAD;
						preDly_nxt = regpwm_pkg::DEAD_PRE_CYC - 3'h1;
					end
				P_DEAD:
					if (preDly_r == 3'h0)
						preSt_nxt = P_LS;
					else
						preDly_nxt = preDly_r - 3'h1;
				P_LS:
					preSt_nxt = P_LS;
				P_OFF:
					preSt_nxt = P_OFF;
				default:
					preSt_nxt = P_OFF;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			preSt_r   <= P_OFF;
			preDly_r  <= 3'h0;
			bootCnt_r <= 2'h0;
		end
		else if (ce)
		begin
			preSt_r   <= preSt_nxt;
			preDly_r  <= preDly_nxt;
			bootCnt_r <= bootCnt_nxt;
		end
	end

	// post converters share one engine
	post_conv #(.SYNC(1'b1)) u_second (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.enable   (cfg_r[regpwm_pkg::CFG_B2_EN]),
		.cycStart (b2Start),
		.pwmOff   (b2PwmOff),
		.dutyCap  (1'b0),
		.skip     (1'b0),
		.hsLimit  (b2HsLimit),
		.lsLimit  (b2LsLimit),
		.hsGate   (b2HsGate),
		.lsGate   (b2LsGate),
		.blanking (blankVec[0])
	);

	post_conv #(.SYNC(1'b1)) u_third (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.enable   (cfg_r[regpwm_pkg::CFG_B3_EN]),
		.cycStart (pairStart),
		.pwmOff   (b3PwmOff),
		.dutyCap  (1'b0),
		.skip     (1'b0),
		.hsLimit  (b3HsLimit),
		.lsLimit  (b3LsLimit),
		.hsGate   (b3HsGate),
		.lsGate   (b3LsGate),
		.blanking (blankVec[1])
	);

	// boost: asynchronous, 75% cap at half of its second tick
	post_conv #(.SYNC(1'b0)) u_boost (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.enable   (cfg_r[regpwm_pkg::CFG_BOOST_EN]),
		.cycStart (pairStart),
		.pwmOff   (boostPwmOff),
		.dutyCap  (tickIdx_r[0] && pastHalf),
		.skip     (boostLowLoad),
		.hsLimit  (boostLimit),
		.lsLimit  (1'b0),
		.hsGate   (boostSwitch),
		.lsGate   (),
		.blanking (blankVec[2])
	);

	spread_gen u_spread (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.enable   (cfg_r[regpwm_pkg::CFG_SPREAD_EN]),
		.triMode  (cfg_r[regpwm_pkg::CFG_SPREAD_TRI]),
		.step     (preStart),
		.code     (freqCode)
	);

	// status word assembled for reads
	always_comb
	begin
		statusWord = 32'h0000_0000;
		statusWord[regpwm_pkg::FLAG_W-1:0] = flags_r;
		statusWord[regpwm_pkg::ST_CODE_LSB +: 4] = freqCode;
		statusWord[regpwm_pkg::ST_MAIN_ACT] = mainAct_r;
		statusWord[regpwm_pkg::ST_PERI_ACT] = periAct_r;
		statusWord[regpwm_pkg::ST_BLANK_LSB +: 3] = blankVec;
		statusWord[regpwm_pkg::ST_MAIN_PIN] = mainResetIn;
		statusWord[regpwm_pkg::ST_PERI_PIN] = periResetIn;
	end

	assign apbSetup  = psel && !penable;
	assign apbAccess = psel && penable && pready;
	assign wrCfg     = apbAccess && pwrite && paddr == regpwm_pkg::CFG_ADDR;
	assign wrStat    = apbAccess && pwrite && paddr == regpwm_pkg::STAT_ADDR;

	// apb slave plus enable and fault bookkeeping
	always_comb
	begin
		ready_nxt  = apbSetup; // one wait-free access cycle
		rdata_nxt  = prdata;
		err_nxt    = pslverr;
		cfg_nxt    = cfg_r;
		flags_nxt  = flags_r;
		ovTrip_nxt = ovTrip_r;
		if (apbSetup)
		begin
			err_nxt   = 1'b0;
			rdata_nxt = 32'h0000_0000;
			case (paddr)
				regpwm_pkg::CFG_ADDR:
					rdata_nxt[regpwm_pkg::CFG_W-1:0] = cfg_r;
				regpwm_pkg::STAT_ADDR:
					rdata_nxt = statusWord;
				default:
					err_nxt = 1'b1;
			endcase
		end
		if (wrCfg)
		begin
			cfg_nxt = pwdata[regpwm_pkg::CFG_W-1:0];
			// restart refused while the overtemp flag still reads 1
			if (flags_r[regpwm_pkg::ST_BOOST_OT])
				cfg_nxt[regpwm_pkg::CFG_BOOST_EN] = 1'b0;
			if (flags_r[regpwm_pkg::ST_LINREG_OT])
				cfg_nxt[regpwm_pkg::CFG_LINREG_EN] = 1'b0;
		end
		if (wrStat)
			flags_nxt = flags_r & ~pwdata[regpwm_pkg::FLAG_W-1:0];
		// hardware sets come last so they win over a clear
		if (boostWinFault)
		begin
			flags_nxt[regpwm_pkg::ST_BOOST_FAIL] = 1'b1;
			cfg_nxt[regpwm_pkg::CFG_BOOST_EN]    = 1'b0;
		end
		if (boostOtIn)
		begin
			flags_nxt[regpwm_pkg::ST_BOOST_OT] = 1'b1;
			cfg_nxt[regpwm_pkg::CFG_BOOST_EN]  = 1'b0;
		end
		if (linregOtIn)
		begin
			flags_nxt[regpwm_pkg::ST_LINREG_OT] = 1'b1;
			cfg_nxt[regpwm_pkg::CFG_LINREG_EN]  = 1'b0;
		end
		if (linregWinFault)
		begin
			flags_nxt[regpwm_pkg::ST_LINREG_FAIL] = 1'b1;
			cfg_nxt[regpwm_pkg::CFG_LINREG_EN]    = 1'b0;
		end
		// trip holds until the sequencer drops its fet request
		if (!fetRequest)
			ovTrip_nxt = 1'b0;
		if (linregOvIn && (voltageCheckState || rampState))
		begin
			ovTrip_nxt = 1'b1;
			flags_nxt[regpwm_pkg::ST_OV_TRIP] = 1'b1;
		end
		fet_nxt = fetRequest && !ovTrip_nxt;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata                <= 32'h0000_0000;
			pready                <= 1'b0;
			pslverr               <= 1'b0;
			cfg_r                 <= regpwm_pkg::CFG_RST;
			flags_r               <= '0;
			ovTrip_r              <= 1'b0;
			externalProtectionFet <= 1'b0;
			errorRequest          <= 1'b0;
			linregOn              <= 1'b0;
			auxSupplyAllow        <= 1'b0;
		end
		else if (ce)
		begin
			prdata                <= rdata_nxt;
			pready                <= ready_nxt;
			pslverr               <= err_nxt;
			cfg_r                 <= cfg_nxt;
			flags_r               <= flags_nxt;
			ovTrip_r              <= ovTrip_nxt;
			externalProtectionFet <= fet_nxt;
			errorRequest          <= ovTrip_nxt;
			linregOn              <= cfg_nxt[regpwm_pkg::CFG_LINREG_EN];
			auxSupplyAllow        <= activeState;
		end
	end

	// reset stretch and peripheral latch
	assign wdRise = watchdogTriggerPin && !wdPrev_r;

	always_comb
	begin
		hold_nxt    = hold_r;
		mainAct_nxt = mainAct_r;
		if (resetTrigger)
		begin
			hold_nxt    = 24'(HOLD_CYC);
			mainAct_nxt = 1'b1;
		end
		else if (hold_r != 24'h000000)
			hold_nxt = hold_r - 24'h000001;
		else
			mainAct_nxt = 1'b0;
		// edges seen while main reset is low are ignored
		periAct_nxt = periAct_r;
		if (mainAct_nxt)
			periAct_nxt = 1'b1;
		else if (wdRise)
			periAct_nxt = 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hold_r       <= 24'(HOLD_CYC);
			mainAct_r    <= 1'b1;
			periAct_r    <= 1'b1;
			wdPrev_r     <= 1'b0;
			mainResetOut <= 1'b0;
			periResetOut <= 1'b0;
			mainResetOeN <= 1'b0;
			periResetOeN <= 1'b0;
		end
		else if (ce)
		begin
			hold_r       <= hold_nxt;
			mainAct_r    <= mainAct_nxt;
			periAct_r    <= periAct_nxt;
			wdPrev_r     <= watchdogTriggerPin;
			mainResetOut <= 1'b0; // open drain: only ever pulls low
			periResetOut <= 1'b0;
			mainResetOeN <= !mainAct_nxt;
			periResetOeN <= !periAct_nxt;
		end
	end

endmodule : regulator_pwm_protection_ctl

`default_nettype wire

// *** test/regpwm_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module regpwm_monitor (
	input wire logic core_clk, rst_n, // clock, reset
	input wire logic preregHsGate, preregLsGate, b2HsGate, b2LsGate, // gates
	input wire logic b3HsGate, b3LsGate, boostSwitch, boostOtIn, // gates, fault
	input wire logic linregOtIn, linregOn, linregOvIn, rampState, // linreg
	input wire logic voltageCheckState, fetRequest, externalProtectionFet, // fet
	input wire logic errorRequest, activeState, auxSupplyAllow, // state
	input wire logic resetTrigger, mainResetOeN, periResetOeN // reset pins
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	AST_PRE_OVERLAP: assert property (!(preregHsGate && preregLsGate))
		else $error("pre gates overlap");
	AST_PRE_DEAD: assert property ($fell(preregHsGate) |-> !preregLsGate [*3])
		else $error("pre dead time short");
	AST_B2_OVERLAP: assert property (!(b2HsGate && b2LsGate))
		else $error("second rail gates overlap");
	AST_B3_OVERLAP: assert property (!(b3HsGate && b3LsGate))
		else $error("third rail gates overlap");
	AST_BOOST_OT: assert property (boostOtIn |-> ##2 !boostSwitch)
		else $error("boost runs hot");
	AST_LINREG_OT: assert property (linregOtIn |-> ##2 !linregOn)
		else $error("linreg runs hot");
	AST_OV_TRIP: assert property (linregOvIn && fetRequest
		&& (voltageCheckState || rampState) |-> ##1 (!externalProtectionFet && errorRequest))
		else $error("overvoltage not tripped");
	AST_AUX: assert property (!activeState |=> !auxSupplyAllow)
		else $error("aux allowed early");
	AST_MAIN_RST: assert property (resetTrigger |=> !mainResetOeN)
		else $error("main reset not driven");
	AST_PERI_RST: assert property (!mainResetOeN |=> !periResetOeN)
		else $error("peripheral reset not driven");
endmodule : regpwm_monitor
`default_nettype wire

// *** test/far_side_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module far_side_model #(
	parameter int TRIP = 200
) (
	input  wire logic core_clk,  // clock
	input  wire logic hsGate,    // pre high gate
	input  wire logic mainOeN,   // main reset drive
	input  wire logic periOeN,   // peripheral drive
	output logic      peakTrip,  // peak comparator
	output logic      mainLevel, // main pin level
	output logic      periLevel  // peripheral pin
);
	int onCnt = 0;
	// inductor ramps while on; trip well before the dropout cap
	always_ff @(posedge core_clk) onCnt <= hsGate ? onCnt + 1 : 0;
	assign peakTrip = hsGate && onCnt >= TRIP;
	// open-drain pins with pull-ups
	assign mainLevel = mainOeN;
	assign periLevel = periOeN;
endmodule : far_side_model
`default_nettype wire

// *** test/regulator_pwm_protection_ctl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module regulator_pwm_protection_ctl_tb;
	// bench state and design pins
	localparam logic [11:0] cfgA = regpwm_pkg::CFG_ADDR, statA = regpwm_pkg::STAT_ADDR;
	int miscompares = 0, checks = 0;
	logic [6:0] cyc = '0;
	logic [31:0] q, pwdata = '0, prdata;
	logic [11:0] paddr = '0;
	logic [3:0] freqCode;
	logic core_clk = 0, rst_n = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic pready, pslverr, preregPeakTrip, preregHsGate, preregLsGate, b2HsGate, b2LsGate;
	logic b3HsGate, b3LsGate, boostSwitch, externalProtectionFet, errorRequest, linregOn;
	logic auxSupplyAllow, mainResetOut, mainResetOeN, periResetOut, periResetOeN;
	logic mainResetIn, periResetIn, b2PwmOff = 0, b3PwmOff = 0, boostPwmOff = 0;
	logic b2HsLimit = 0, b2LsLimit = 0, b3HsLimit = 0, b3LsLimit = 0, boostLimit = 0;
	logic boostLowLoad = 0, boostWinFault = 0, boostOtIn = 0, linregWinFault = 0;
	logic linregOtIn = 0, linregOvIn = 0, voltageCheckState = 0, rampState = 0;
	logic activeState = 0, fetRequest = 0, resetTrigger = 0, watchdogTriggerPin = 0;
	regulator_pwm_protection_ctl #(.MAIN_RESET_OUT_HOLD_US(1)) dut (.*);
	far_side_model far (.core_clk(core_clk), .hsGate(preregHsGate), .mainOeN(mainResetOeN),
		.periOeN(periResetOeN), .peakTrip(preregPeakTrip), .mainLevel(mainResetIn),
		.periLevel(periResetIn));
	// clock; crude modulator ends on-time
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cyc <= cyc + 7'h1;
		{b2PwmOff, b3PwmOff, boostPwmOff} <= {3{cyc[5]}};
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// one transfer, request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		q = prdata;
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic t_regs;
		apb(0, cfgA, '0);
		chk("cfg reset", 32'(regpwm_pkg::CFG_RST), q);
		apb(0, 12'h008, '0);
		chk("unmapped err", 32'h1, 32'(pslverr));
		$display("regs done");
	endtask : t_regs
	task automatic t_resets;
		repeat (120) @(posedge core_clk);
		chk("main free", 32'h1, 32'(mainResetOeN));
		chk("peri latched", 32'h0, 32'(periResetOeN));
		chk("od low", 32'h0, 32'(mainResetOut | periResetOut));
		watchdogTriggerPin <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("peri free", 32'h1, 32'(periResetOeN));
		{watchdogTriggerPin, resetTrigger} <= 2'b01;
		@(posedge core_clk);
		resetTrigger <= 1'b0;
		repeat (60) @(posedge core_clk);
		chk("main held", 32'h0, 32'(mainResetOeN));
		chk("peri slave", 32'h0, 32'(periResetOeN));
		repeat (60) @(posedge core_clk);
		chk("main end", 32'h1, 32'(mainResetOeN));
		$display("resets done");
	endtask : t_resets
	task automatic t_pre;
		repeat (1300) if (preregHsGate !== 1'b1) @(posedge core_clk);
		chk("high on", 32'h1, 32'(preregHsGate));
		repeat (700) if (preregHsGate !== 1'b0) @(posedge core_clk);
		repeat (5) @(posedge core_clk);
		chk("low after dead", 32'h1, 32'(preregLsGate));
		$display("pre done");
	endtask : t_pre
	task automatic t_boost;
		apb(1, cfgA, 32'h31);
		boostWinFault <= 1'b1;
		@(posedge core_clk);
		boostWinFault <= 1'b0;
		apb(0, statA, '0);
		chk("fail flag", 32'h1, 32'(q[0]));
		apb(1, statA, 32'h1);
		apb(1, cfgA, 32'h31);
		boostOtIn <= 1'b1;
		repeat (3) @(posedge core_clk);
		boostOtIn <= 1'b0;
		apb(0, statA, '0);
		chk("ot flag", 32'h1, 32'(q[1]));
		apb(1, cfgA, 32'h31);
		apb(0, cfgA, '0);
		chk("refused", 32'h0, 32'(q[0]));
		apb(1, statA, 32'h2);
		apb(1, cfgA, 32'h31);
		apb(0, cfgA, '0);
		chk("restart", 32'h1, 32'(q[0]));
		$display("boost done");
	endtask : t_boost
	task automatic t_limits;
		logic seen;
		seen = 1'b0;
		{b2HsLimit, b3HsLimit, boostLimit} <= 3'b111;
		repeat (720) @(posedge core_clk);
		repeat (1200)
		begin
			@(posedge core_clk);
			seen = seen | b2HsGate | b3HsGate | boostSwitch;
		end
		chk("blanked", 32'h0, 32'(seen));
		{b2HsLimit, b3HsLimit, boostLimit} <= 3'b000;
		$display("limits done");
	endtask : t_limits
	task automatic t_linreg;
		apb(1, cfgA, 32'h32);
		@(posedge core_clk);
		chk("on", 32'h1, 32'(linregOn));
		linregWinFault <= 1'b1;
		@(posedge core_clk);
		linregWinFault <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("off", 32'h0, 32'(linregOn));
		apb(0, statA, '0);
		chk("fail flag", 32'h1, 32'(q[3]));
		linregOtIn <= 1'b1;
		@(posedge core_clk);
		linregOtIn <= 1'b0;
		apb(1, cfgA, 32'h32);
		apb(0, cfgA, '0);
		chk("refused", 32'h0, 32'(q[1]));
		$display("linreg done");
	endtask : t_linreg
	task automatic t_ov;
		{voltageCheckState, fetRequest, activeState} <= 3'b111;
		repeat (3) @(posedge core_clk);
		chk("aux on", 32'h1, 32'(auxSupplyAllow));
		linregOvIn <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("fet off", 32'h0, 32'(externalProtectionFet));
		chk("error", 32'h1, 32'(errorRequest));
		{linregOvIn, voltageCheckState, fetRequest, activeState} <= 4'h0;
		repeat (3) @(posedge core_clk);
		chk("aux off", 32'h0, 32'(auxSupplyAllow));
		$display("ov done");
	endtask : t_ov
	task automatic t_spread;
		logic [3:0] prev;
		for (int m = 0; m < 2; m++)
		begin
			apb(1, cfgA, {26'h0, 2'h3, m[0], 3'h4});
			prev = freqCode;
			repeat (4)
			begin
				repeat (1300) if (freqCode === prev) @(posedge core_clk);
				chk("step", 32'h1, 32'(freqCode > prev ? freqCode - prev : prev - freqCode));
				prev = freqCode;
			end
			apb(1, cfgA, 32'h30);
			repeat (2) @(posedge core_clk);
			chk("nominal", 32'h0, 32'(freqCode));
		end
		$display("spread done");
	endtask : t_spread
	task automatic conclude;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	// main sequence
	initial
	begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		t_regs;
		t_resets;
		t_pre;
		t_boost;
		t_limits;
		t_linreg;
		t_ov;
		t_spread;
		conclude;
	end
	// hang guard
	initial
	begin
		#800000;
		miscompares++;
		conclude;
	end
endmodule : regulator_pwm_protection_ctl_tb
bind regulator_pwm_protection_ctl regpwm_monitor mon (.*);
`default_nettype wire
